/* rtl/ast_tx_top.sv */
// async serial transmitter with baud generator and transmit flags, axi4-lite registers
// assumes one 250 MHz clock, synchronous active-low reset, synchronous pin inputs
// How it works
// R01: frame is start, 8/9 data, stop
// R02: data bits shifted least significant first
// R03: eight-bit divisor register drives baud generator
// R04: generator runs x16 high speed, x64 otherwise
// R05: transmit shares format and rate settings
// R06: no parity hardware; ninth bit carries it
// R07: sleep halts generator and shifting
// R08: async mode only when sync bit clear
// R09: shifter reloads only after stop bit
// R10: buffer transfer takes one cycle, sets flag
// R11: flag software read-only, cleared by buffer write
// R12: interrupt request gated by its enable
// R13: shifter-empty status readable, polled, no interrupt
// R14: shifter not visible in register map
// R15: enable sets flag, buffer write clears it
// R16: start waits for data and shift tick
// R17: buffer-then-enable order also starts transmission
// R18: write when shifter empty transfers at once
// R19: enable clear aborts frame, pin released
// R20: software writes ninth bit before data
// R21: software follows documented setup order
// R22: bit rate is clock/(16|64*(divisor+1))
// R23: line idles high; start low, stop high
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module ast_tx_top
  import ast_pkg::*;
(
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [ast_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [ast_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ast_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [ast_pkg::AXI_DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          sleep_req,
  output logic                               transmit_pin_o,
  output logic                               transmit_pin_oe_n,
  output logic                               tx_irq_req
);
  import ast_pkg::*;

  // register storage
  logic [7:0]  icon_reg;          // interrupt_control, only enables kept
  logic [7:0]  ie_reg;            // peripheral_irq_enables
  logic        serial_port_enable_reg;          // serial_port_enable
  logic [7:0]  transmit_status_control_reg;         // transmit_status_control, writable bits
  logic [7:0]  divisor_reg;       // baud_divisor
  logic [7:0]  buffer_reg;        // transmit_buffer contents
  logic        buf_full_reg;      // buffer holds an unsent character
  logic        flag_reg;          // tx_buffer_empty_flag

  // bus handshake state
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  // transmitter state
  ast_state_t  state_reg;
  logic [8:0]  shifter_reg;       // transmit_shifter, not mapped
  logic [3:0]  bit_cnt_reg;       // data bit index
  logic [3:0]  last_bit_reg;      // frame length latched at load
  logic        line_reg;          // registered line level
  logic [7:0]  div_cnt_reg;       // baud divisor down-counter
  logic [5:0]  os_cnt_reg;        // oversample counter

  // decoded controls
  logic        tx_en;
  logic        async_active;
  logic        gen_en;
  logic        os_tick;
  logic        bit_tick;
  logic [5:0]  os_last;
  logic        load_now;
  logic        wr_fire;
  logic        rd_fire;
  logic [9:0]  wr_idx;
  logic [9:0]  rd_idx;
  logic        wr_byte0;
  logic [7:0]  wdat;
  logic        wr_buf;
  logic        wr_transmit_status_control;
  logic        transmit_enable_rise;

  // write channel accepted only when both address and data are present
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign s_axi_wready  = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  // one read outstanding; the next address waits for the data to drain
  assign s_axi_arready = ~rvalid_reg;
  assign rd_fire       = s_axi_arvalid & ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  assign wr_idx   = s_axi_awaddr[11:2];
  assign rd_idx   = s_axi_araddr[11:2];
  assign wr_byte0 = wr_fire & s_axi_wstrb[0];
  assign wdat     = s_axi_wdata[7:0];
  assign wr_buf   = wr_byte0 & (wr_idx == IDX_TRANSMIT_BUFFER);
  assign wr_transmit_status_control = wr_byte0 & (wr_idx == IDX_TRANSMIT_STATUS_CTRL);
  assign transmit_enable_rise = wr_transmit_status_control & wdat[BIT_TRANSMIT_ENABLE] & ~transmit_status_control_reg[BIT_TRANSMIT_ENABLE];

  // transmitter runs only with port on, enable set, async mode
  assign tx_en        = transmit_status_control_reg[BIT_TRANSMIT_ENABLE];
  assign async_active = serial_port_enable_reg & ~transmit_status_control_reg[BIT_SYNC_SELECT];                 // R08
  assign gen_en       = async_active;                                         // R05

  // generator ticks; sleep freezes both ticks
  assign os_last  = transmit_status_control_reg[BIT_HIGH_SPEED_SELECT] ? OS_LAST_HIGH : OS_LAST_LOW; // R04
  assign os_tick  = gen_en & ~sleep_req & (div_cnt_reg == 8'h00);              // R07
  assign bit_tick = os_tick & (os_cnt_reg == os_last);                         // R22

  // transfer buffer to shifter: idle, or right as the stop bit ends
  assign load_now = async_active & tx_en & buf_full_reg & ~sleep_req &
                    ((state_reg == ST_IDLE) | ((state_reg == ST_STOP) & bit_tick)); // R09 R17 R18

  // interrupt request follows flag only while enabled
  assign tx_irq_req = flag_reg & ie_reg[BIT_TX_BUFFER_EMPTY];                  // R12

  // pin driven only while transmitter is live; released otherwise
  assign transmit_pin_o    = line_reg;
  assign transmit_pin_oe_n = ~(async_active & tx_en);                          // R19

  // write response: every write answered, unmapped ones with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      case (wr_idx)
        IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_IRQ_FLAGS, IDX_RECEIVE_STATUS_CTRL,
        IDX_TRANSMIT_BUFFER, IDX_PERIPHERAL_IRQ_ENS, IDX_TRANSMIT_STATUS_CTRL,
        IDX_BAUD_DIVISOR: bresp_reg <= RESP_OKAY;
        default:          bresp_reg <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // software-written control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icon_reg    <= RST_INTERRUPT_CONTROL;
      ie_reg      <= RST_PERIPHERAL_IRQ_ENS;
      serial_port_enable_reg    <= RST_RECEIVE_STATUS_CTRL[BIT_SERIAL_PORT_ENABLE];
      transmit_status_control_reg   <= RST_TRANSMIT_STATUS_CTRL;
      divisor_reg <= RST_BAUD_DIVISOR;
    end else if (wr_byte0) begin
      case (wr_idx)
        // only the two enables live here
        IDX_INTERRUPT_CONTROL: begin
          icon_reg[BIT_GLOBAL_IRQ_ENABLE]     <= wdat[BIT_GLOBAL_IRQ_ENABLE];
          icon_reg[BIT_PERIPHERAL_IRQ_ENABLE] <= wdat[BIT_PERIPHERAL_IRQ_ENABLE];
        end
        IDX_PERIPHERAL_IRQ_ENS:  ie_reg[BIT_TX_BUFFER_EMPTY] <= wdat[BIT_TX_BUFFER_EMPTY];
        IDX_RECEIVE_STATUS_CTRL: serial_port_enable_reg <= wdat[BIT_SERIAL_PORT_ENABLE];
        // shifter-empty bit is read-only, stored bit ignored
        IDX_TRANSMIT_STATUS_CTRL: begin
          transmit_status_control_reg[BIT_CLOCK_SOURCE_SEL]   <= wdat[BIT_CLOCK_SOURCE_SEL];
          transmit_status_control_reg[BIT_NINE_BIT_TX_SELECT] <= wdat[BIT_NINE_BIT_TX_SELECT];
          transmit_status_control_reg[BIT_TRANSMIT_ENABLE]    <= wdat[BIT_TRANSMIT_ENABLE];
          transmit_status_control_reg[BIT_SYNC_SELECT]        <= wdat[BIT_SYNC_SELECT];
          transmit_status_control_reg[BIT_HIGH_SPEED_SELECT]  <= wdat[BIT_HIGH_SPEED_SELECT];
          transmit_status_control_reg[BIT_NINTH_TX_BIT]       <= wdat[BIT_NINTH_TX_BIT];
        end
        IDX_BAUD_DIVISOR: divisor_reg <= wdat;                                 // R03
        default: ;
      endcase
    end
  end

  // transmit buffer and its occupancy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffer_reg   <= RST_TRANSMIT_BUFFER;
      buf_full_reg <= 1'b0;
    end else if (wr_buf) begin
      // a new write refills even if a transfer takes the old byte
      buffer_reg   <= wdat;
      buf_full_reg <= 1'b1;
    end else if (load_now) begin
      buf_full_reg <= 1'b0;                                                    // R10
    end
  end

  // buffer-empty flag: software clears it only by writing the buffer, never directly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
    end else if (wr_buf) begin
      // write beats a same-cycle transfer: flag tracks buffer contents
      flag_reg <= 1'b0;                                                        // R11 R15
    end else if (load_now | transmit_enable_rise) begin
      flag_reg <= 1'b1;                                                        // R10 R15
    end
  end

  // read data: status bits are live state, unused bits read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
      case (rd_idx)
        IDX_INTERRUPT_CONTROL:    rdata_reg[7:0] <= icon_reg;
        IDX_PERIPHERAL_IRQ_FLAGS: rdata_reg[BIT_TX_BUFFER_EMPTY] <= flag_reg;
        IDX_RECEIVE_STATUS_CTRL:  rdata_reg[BIT_SERIAL_PORT_ENABLE] <= serial_port_enable_reg;
        IDX_TRANSMIT_BUFFER:      rdata_reg[7:0] <= buffer_reg;
        IDX_PERIPHERAL_IRQ_ENS:   rdata_reg[7:0] <= ie_reg;
        IDX_TRANSMIT_STATUS_CTRL: begin
          rdata_reg[7:0] <= transmit_status_control_reg;
          rdata_reg[BIT_SHIFTER_EMPTY_STATUS] <= (state_reg == ST_IDLE);      // R13
        end
        IDX_BAUD_DIVISOR:         rdata_reg[7:0] <= divisor_reg;
        // shifter has no index, so it falls here
        default:                  rresp_reg <= RESP_SLVERR;                    // R14
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // baud generator: divisor down-counter then x16/x64 oversample count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg <= RST_BAUD_DIVISOR;
      os_cnt_reg  <= 6'h00;
    end else if (!gen_en) begin
      div_cnt_reg <= divisor_reg;
      os_cnt_reg  <= 6'h00;
    end else if (!sleep_req) begin                                             // R07
      if (os_tick) begin
        div_cnt_reg <= divisor_reg;                                            // R03
        // a speed change mid-count wraps cleanly at the new limit
        os_cnt_reg  <= (os_cnt_reg >= os_last) ? 6'h00 : os_cnt_reg + 6'h01;
      end else begin
        div_cnt_reg <= div_cnt_reg - 8'h01;
      end
    end
  end

  // transmit sequencer; no parity stage exists by design
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= ST_IDLE;
      shifter_reg  <= 9'h000;
      bit_cnt_reg  <= 4'h0;
      last_bit_reg <= LAST_BIT_8;
      line_reg     <= 1'b1;
    end else if (!(async_active & tx_en)) begin
      // abort: drop the frame, line back to idle level
      // buffer keeps its byte; it goes out once re-enabled
      state_reg <= ST_IDLE;                                                    // R19
      line_reg  <= 1'b1;                                                       // R23
    end else if (load_now) begin
      // ninth bit sampled now, so it must already be written
      shifter_reg  <= {transmit_status_control_reg[BIT_NINTH_TX_BIT], buffer_reg};              // R06 R20
      last_bit_reg <= transmit_status_control_reg[BIT_NINE_BIT_TX_SELECT] ? LAST_BIT_9 : LAST_BIT_8; // R01
      bit_cnt_reg  <= 4'h0;
      if (state_reg == ST_STOP) begin
        // back-to-back: next start bit begins on this same tick
        state_reg <= ST_START;
        line_reg  <= 1'b0;
      end else begin
        state_reg <= ST_WAIT;                                                  // R16
      end
    end else if (bit_tick) begin
      case (state_reg)
        // first shift clock after load launches the start bit
        ST_WAIT: begin
          state_reg <= ST_START;
          line_reg  <= 1'b0;                                                   // R16 R23
        end
        ST_START: begin
          state_reg <= ST_DATA;
          line_reg  <= shifter_reg[0];                                         // R02
        end
        ST_DATA: begin
          if (bit_cnt_reg == last_bit_reg) begin
            state_reg <= ST_STOP;
            line_reg  <= 1'b1;                                                 // R23
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shifter_reg <= {1'b0, shifter_reg[8:1]};                           // R02
            line_reg    <= shifter_reg[1];
          end
        end
        // stop ended with nothing queued
        ST_STOP: begin
          state_reg <= ST_IDLE;
          line_reg  <= 1'b1;
        end
        default: begin
          state_reg <= ST_IDLE;
          line_reg  <= 1'b1;
        end
      endcase
    end
  end

  // checks on the transmitter
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // frame shape on the line
  a_start_bit_low:  assert property (state_reg == ST_START |-> !line_reg) // R01
    else $error("start bit not low");
  a_stop_idle_high: assert property ((state_reg == ST_STOP || state_reg == ST_IDLE) |-> line_reg) // R23
    else $error("stop or idle not high");
  a_lsb_first_out:  assert property ((state_reg == ST_START && bit_tick && async_active && tx_en && !load_now) // R02
                                     |=> (line_reg == $past(shifter_reg[0])))
    else $error("first data bit not lsb");
  // buffer and flag handshake
  a_reload_after_stop: assert property (load_now |-> (state_reg == ST_IDLE || (state_reg == ST_STOP && bit_tick))) // R09
    else $error("shifter reloaded mid frame");
  a_load_sets_flag: assert property ((load_now && !wr_buf) |=> flag_reg && !buf_full_reg) // R10
    else $error("transfer did not empty buffer");
  a_write_clears_flag: assert property (wr_buf |=> !flag_reg ##0 buf_full_reg) // R11
    else $error("buffer write left flag set");
  a_flag_no_clear:  assert property ((!wr_buf && !load_now && !transmit_enable_rise) |=> flag_reg == $past(flag_reg)) // R11
    else $error("flag changed without cause");
  a_irq_needs_enable: assert property (tx_irq_req |-> ie_reg[BIT_TX_BUFFER_EMPTY] && flag_reg) // R12
    else $error("interrupt without enable");
  // divisor reload; enable, mode and sleep gating
  a_sleep_no_tick:  assert property (sleep_req |-> !os_tick && !load_now) // R07
    else $error("activity during sleep");
  a_div_reload:     assert property (os_tick |=> div_cnt_reg == $past(divisor_reg)) // R03
    else $error("divisor not reloaded on tick");
  a_abort_release:  assert property (($fell(tx_en) && $past(state_reg) != ST_IDLE) |-> // R19
                                     transmit_pin_oe_n ##1 (line_reg && state_reg == ST_IDLE))
    else $error("abort left frame running");
  a_disable_hiz:    assert property (!tx_en |-> transmit_pin_oe_n ##1 state_reg == ST_IDLE) // R19
    else $error("pin driven while disabled");
  a_sync_stops:     assert property (transmit_status_control_reg[BIT_SYNC_SELECT] |=> state_reg == ST_IDLE) // R08
    else $error("async ran in sync mode");
  a_enable_sets_flag: assert property (transmit_enable_rise && !wr_buf |=> flag_reg) // R15
    else $error("enable did not set flag");

  // coverage of the main traffic cases
  c_back_to_back:   cover property (state_reg == ST_STOP && load_now);
  c_nine_bit_frame: cover property (state_reg == ST_DATA && bit_cnt_reg == LAST_BIT_9);
  c_abort_in_frame: cover property (state_reg == ST_DATA ##1 !tx_en);
  c_high_speed_bit: cover property (bit_tick && transmit_status_control_reg[BIT_HIGH_SPEED_SELECT]);
  c_sleep_hold:     cover property (sleep_req && buf_full_reg && state_reg == ST_IDLE);

endmodule

/* pkg/ast_pkg.sv */
// constants for the async serial transmitter: register indexes, fields, resets
// assumes a 32-bit axi4-lite bus; byte address of a register is four times its index
package ast_pkg;

  localparam int AXI_ADDR_W = 12;                          // byte address width
  localparam int AXI_DATA_W = 32;                          // bus data width

  // register indexes (byte address = index * 4)
  localparam logic [9:0] IDX_INTERRUPT_CONTROL   = 10'h00B;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_FLAGS = 10'h00C;
  localparam logic [9:0] IDX_RECEIVE_STATUS_CTRL = 10'h018;
  localparam logic [9:0] IDX_TRANSMIT_BUFFER     = 10'h019;
  localparam logic [9:0] IDX_PERIPHERAL_IRQ_ENS  = 10'h08C;
  localparam logic [9:0] IDX_TRANSMIT_STATUS_CTRL = 10'h098;
  localparam logic [9:0] IDX_BAUD_DIVISOR        = 10'h099;

  // interrupt_control fields
  localparam int BIT_GLOBAL_IRQ_ENABLE     = 7;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
  // peripheral_irq_flags / peripheral_irq_enables field
  localparam int BIT_TX_BUFFER_EMPTY       = 4;
  // receive_status_control field
  localparam int BIT_SERIAL_PORT_ENABLE    = 7;
  // transmit_status_control fields
  localparam int BIT_CLOCK_SOURCE_SEL      = 7;
  localparam int BIT_NINE_BIT_TX_SELECT    = 6;
  localparam int BIT_TRANSMIT_ENABLE       = 5;
  localparam int BIT_SYNC_SELECT           = 4;
  localparam int BIT_HIGH_SPEED_SELECT     = 2;
  localparam int BIT_SHIFTER_EMPTY_STATUS  = 1;
  localparam int BIT_NINTH_TX_BIT          = 0;

  // reset values
  localparam logic [7:0] RST_INTERRUPT_CONTROL   = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_ENS  = 8'h00;
  localparam logic [7:0] RST_RECEIVE_STATUS_CTRL = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_BUFFER     = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS_CTRL = 8'h02;
  localparam logic [7:0] RST_BAUD_DIVISOR        = 8'h00;

  // oversample counts per bit: x16 when high speed, x64 otherwise
  localparam logic [5:0] OS_LAST_HIGH = 6'h0F;
  localparam logic [5:0] OS_LAST_LOW  = 6'h3F;

  // data bit counts per frame, less one
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // transmitter states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_START,
    ST_DATA,
    ST_STOP
  } ast_state_t;

endpackage

/* test/ast_rx_model.sv */
// remote asynchronous receiver watching the transmit line
// assumes the bench resolves the line with a pull-up while the pin is released
`timescale 1ns/1ns
module ast_rx_model (
  input  wire logic       aclk,
  input  wire logic       line,      // resolved line level
  input  wire logic       oe_n,      // pin driven when low
  input  wire logic [9:0] bit_cyc,   // clocks per bit
  input  wire logic       nine,      // nine data bits
  output logic [9:0]      rx_data,   // {stop, data}
  output logic            rx_valid   // one-cycle pulse
);
  logic [8:0] sh;  // assembled bits
  logic       ok;  // frame not aborted
  initial begin
    rx_valid = 1'h0;
    rx_data = 10'h000;
  end
  // hunt start, sample mid-bit, lsb first, stop last
  always begin
    @(posedge aclk);
    if (!oe_n && line === 1'h0) begin
      ok = 1'h1;
      sh = 9'h000;
      repeat (bit_cyc / 2) @(posedge aclk);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (bit_cyc) @(posedge aclk);
        sh[i] = line;
        ok &= !oe_n;
      end
      repeat (bit_cyc) @(posedge aclk);
      // a frame cut by release is dropped; a bad stop is still reported
      if (ok && !oe_n) begin
        rx_data <= {line, sh};
        rx_valid <= 1'h1;
        @(posedge aclk);
        rx_valid <= 1'h0;
      end
    end
  end
endmodule

/* test/ast_tx_top_test.sv */
// self-checking bench for the async serial transmitter
// assumes ast_pkg constants and the receiver model beside it
`timescale 1ns/1ns
module ast_tx_top_test;
  import ast_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, sleep_req = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, pin_o, oe_n, irq;
  logic [1:0]  bresp, rresp;
  logic [9:0]  bit_cyc = 10'h010, rx_data;
  logic        nine = 1'h0, rx_valid, line;
  logic [7:0]  d;              // random payload
  logic [33:0] rd_q[$];        // expected {resp, data}
  logic [9:0]  fr_q[$];        // expected {stop, data}
  int          errors = 0, compares = 0;
  assign line = oe_n ? 1'h1 : pin_o;  // pull-up while released
  // clock: 4 ns period
  always #2 aclk = ~aclk;
  ast_tx_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep_req(sleep_req), .transmit_pin_o(pin_o),
    .transmit_pin_oe_n(oe_n), .tx_irq_req(irq));
  ast_rx_model rx_u (.aclk(aclk), .line(line), .oe_n(oe_n), .bit_cyc(bit_cyc), .nine(nine),
    .rx_data(rx_data), .rx_valid(rx_valid));
  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // bounded waits end the run on expiry
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      $display("BAD t=%0t wait timed out", $time);
      stop_test();
    end
  endtask
  // axi4-lite write: address and data offered together
  task automatic wr(input logic [9:0] i, input logic [7:0] v, input logic [1:0] r = RESP_OKAY);
    int n;
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin @(posedge aclk); n++; end while (!(awready && wready) && n < 2000);
    guard(n, 2000);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    n = 0;
    do begin @(posedge aclk); n++; end while (!bvalid && n < 2000);
    guard(n, 2000);
    bready <= 1'h0;
    chk(bresp, r, "bresp");
    @(posedge aclk);  // next call never re-raises in the step it fell
  endtask
  // axi4-lite read; the watcher compares the answer
  task automatic rd(input logic [9:0] i, input logic [7:0] v, input logic [1:0] r = RESP_OKAY);
    int n;
    rd_q.push_back({r, 24'h0, v});
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin @(posedge aclk); n++; end while (!arready && n < 2000);
    guard(n, 2000);
    arvalid <= 1'h0;
    n = 0;
    do begin @(posedge aclk); n++; end while (!rvalid && n < 2000);
    guard(n, 2000);
    rready <= 1'h0;
    @(posedge aclk);  // next call never re-raises in the step it fell
  endtask
  // queue a frame and write it to the buffer
  task automatic send(input logic ninth);
    d = $urandom;
    fr_q.push_back({1'h1, ninth, d});
    wr(IDX_TRANSMIT_BUFFER, d);
  endtask
  task automatic drain;
    int n = 0;
    while (fr_q.size() > 0 && n < 20000) begin @(posedge aclk); n++; end
    guard(n, 20000);
    // the receiver reports mid stop bit; let the stop bit end
    repeat (bit_cyc) @(posedge aclk);
  endtask
  // watchers take the oldest note when a result appears
  always @(posedge aclk) begin
    if (rvalid && rready)
      chk({rresp, rdata}, rd_q.pop_front(), "read");
    if (rx_valid)
      chk({24'h0, rx_data}, {24'h0, fr_q.pop_front()}, "frame");
  end
  initial begin
    void'($urandom(76637));
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(IDX_TRANSMIT_STATUS_CTRL, RST_TRANSMIT_STATUS_CTRL);
    rd(IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    rd(IDX_BAUD_DIVISOR, RST_BAUD_DIVISOR);
    rd(10'h3FF, 8'h00, RESP_SLVERR);
    wr(10'h3FF, 8'hA5, RESP_SLVERR);
    chk(oe_n, 1'h1, "pin released");
    wr(IDX_BAUD_DIVISOR, 8'h00);
    wr(IDX_TRANSMIT_STATUS_CTRL, 8'h04);
    wr(IDX_RECEIVE_STATUS_CTRL, 8'h80);
    wr(IDX_PERIPHERAL_IRQ_ENS, 8'h10);
    chk(irq, 1'h0, "irq idle");
    wr(IDX_TRANSMIT_STATUS_CTRL, 8'h24);
    rd(IDX_PERIPHERAL_IRQ_FLAGS, 8'h10);
    chk(irq, 1'h1, "irq on");
    chk(oe_n, 1'h0, "pin driven");
    wr(IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    rd(IDX_PERIPHERAL_IRQ_FLAGS, 8'h10);
    wr(IDX_PERIPHERAL_IRQ_ENS, 8'h00);
    chk(irq, 1'h0, "irq masked");
    send(1'h0);
    send(1'h0);
    rd(IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    rd(IDX_TRANSMIT_STATUS_CTRL, 8'h24);
    drain();
    rd(IDX_TRANSMIT_STATUS_CTRL, 8'h26);
    rd(IDX_PERIPHERAL_IRQ_FLAGS, 8'h10);
    nine <= 1'h1;
    wr(IDX_TRANSMIT_STATUS_CTRL, 8'h65);
    send(1'h1);
    drain();
    nine <= 1'h0;
    bit_cyc <= 10'h0C0;
    wr(IDX_BAUD_DIVISOR, 8'h02);
    wr(IDX_TRANSMIT_STATUS_CTRL, 8'h20);
    sleep_req <= 1'h1;
    send(1'h0);
    repeat (500) @(posedge aclk);
    chk(line, 1'h1, "asleep line");
    sleep_req <= 1'h0;
    drain();
    wr(IDX_TRANSMIT_STATUS_CTRL, 8'h00);
    send(1'h0);
    repeat (500) @(posedge aclk);
    wr(IDX_TRANSMIT_STATUS_CTRL, 8'h20);
    drain();
    wr(IDX_TRANSMIT_BUFFER, 8'h5A);
    repeat (600) @(posedge aclk);
    wr(IDX_TRANSMIT_STATUS_CTRL, 8'h00);
    chk(oe_n, 1'h1, "abort release");
    rd(IDX_TRANSMIT_STATUS_CTRL, 8'h02);
    wr(IDX_TRANSMIT_STATUS_CTRL, 8'h30);
    chk(oe_n, 1'h1, "sync mode");
    repeat (2500) @(posedge aclk);
    stop_test();
  end
endmodule
